// ### common/wdc_pkg.sv
// package: constants and types for the watchdog-clear instruction block
package wdc_pkg;
    // instruction word and decode
    localparam int           INSTR_W       = 14;
    localparam logic [13:0]  OP_WDT_CLEAR  = 14'h0064;
    // watchdog counter and prescaler
    localparam int           WDT_W         = 8;
    localparam int           PRESC_W       = 8;
    localparam logic [7:0]   WDT_CLEAR_VAL = 8'h00;
    localparam logic [7:0]   PRESC_CLR_VAL = 8'h00;
    localparam logic [7:0]   WDT_RST_VAL   = 8'h00;
    localparam logic [7:0]   PRESC_RST_VAL = 8'h00;
    localparam logic [7:0]   PRESC_DFLT    = 8'hFF;
    // status flags, active low
    localparam logic         FLAG_SET      = 1'h1;
    localparam logic         FLAG_CLR      = 1'h0;
    localparam logic         FLAG_RST_VAL  = 1'h1;
    // instruction cycle phases, one-hot
    typedef enum logic [3:0] {
        PH_Q1 = 4'h1,
        PH_Q2 = 4'h2,
        PH_Q3 = 4'h4,
        PH_Q4 = 4'h8
    } wdc_phase_type;
endpackage

// ### common/wdc_phase_if.sv
// interface: instruction-cycle phase carried from the phase generator
`timescale 1ns/1ps
`default_nettype none
interface wdc_phase_if;
    wdc_pkg::wdc_phase_type phase;
    logic                   cycle_end;
    modport gen (output phase, output cycle_end);
    modport use_ph (input phase, input cycle_end);
endinterface
`default_nettype wire

// ### core/wdc_phase_gen.sv
// module: four-phase instruction cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module wdc_phase_gen (
    // clock and reset
    input  wire logic   core_clk,
    input  wire logic   rst,
    // phase out
    wdc_phase_if.gen    ph
);
    wdc_pkg::wdc_phase_type phase_ff;
    wdc_pkg::wdc_phase_type nxt_phase;

    always_comb begin
        case (phase_ff)
            wdc_pkg::PH_Q1: nxt_phase = wdc_pkg::PH_Q2;
            wdc_pkg::PH_Q2: nxt_phase = wdc_pkg::PH_Q3;
            wdc_pkg::PH_Q3: nxt_phase = wdc_pkg::PH_Q4;
            wdc_pkg::PH_Q4: nxt_phase = wdc_pkg::PH_Q1;
            default:        nxt_phase = wdc_pkg::PH_Q1;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase_ff <= wdc_pkg::PH_Q1;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    assign ph.phase     = phase_ff;
    assign ph.cycle_end = (phase_ff == wdc_pkg::PH_Q4);
endmodule
`default_nettype wire

// ### core/wdc_top.sv
// module: watchdog-clear instruction execution with counter, prescaler and status flags
// ****************************************************************
// Summary of operation
// - The decoder takes the 14-bit word 00 0000 0110 0100, with no operands, as the watchdog-clear instruction.
// - Executing it loads the watchdog counter with 00h.
// - It also clears the watchdog prescaler to zero so prescaled counting restarts.
// - It sets the active-low time-out and power-down flags to 1 and touches no other flag.
// - It is one program word long and finishes within one instruction cycle.
// - Phase one decodes, phase two idles, phase three processes, phase four clears the counter.
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
module wdc_top #(
    parameter int          WDT_W   = wdc_pkg::WDT_W,
    parameter int          PRESC_W = wdc_pkg::PRESC_W,
    parameter logic [7:0]  PRESC_MAX = wdc_pkg::PRESC_DFLT
) (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // instruction stream, sampled in phase one
    input  wire logic [13:0]          instr_word,
    input  wire logic                 instr_valid,
    // watchdog time base and power events
    input  wire logic                 wdt_tick,
    input  wire logic                 sleep_entry,
    // watchdog state
    output logic [WDT_W-1:0]          watchdog_counter,
    output logic [PRESC_W-1:0]        wdt_prescaler,
    output logic                      wdt_timeout,
    // status flags, active low
    output logic                      timeout_flag_n,
    output logic                      powerdown_flag_n,
    // phase and completion
    output logic [3:0]                q_phase,
    output logic                      wdt_clear_done
);
    // ****************************************************************
    // phase sequencing
    // ****************************************************************
    wdc_phase_if ph_if ();

    wdc_phase_gen u_phase (
        .core_clk (core_clk),
        .rst      (rst),
        .ph       (ph_if.gen)
    );

    wire logic in_q1 = (ph_if.phase == wdc_pkg::PH_Q1);
    wire logic in_q3 = (ph_if.phase == wdc_pkg::PH_Q3);
    // end-of-cycle mark from the sequencer is the phase-four indicator
    wire logic in_q4 = ph_if.cycle_end;

    // ****************************************************************
    // decode and execute pipeline
    // ****************************************************************
    logic                  hit_ff;
    logic                  exec_ff;
    logic [WDT_W-1:0]      wdt_ff;
    logic [PRESC_W-1:0]    presc_ff;
    logic                  to_n_ff;
    logic                  pwrdn_n_ff;
    logic                  tout_ff;
    logic                  done_ff;
    logic [3:0]            phase_out_ff;

    wire logic opcode_hit = instr_valid && (instr_word == wdc_pkg::OP_WDT_CLEAR);
    wire logic do_clear   = in_q4 && exec_ff;

    // free-running watchdog time base; a clear always beats a tick in the same cycle
    wire logic presc_wrap = wdt_tick && (presc_ff == PRESC_W'(PRESC_MAX));
    wire logic wdt_wrap   = presc_wrap && (wdt_ff == {WDT_W{1'b1}});
    wire logic [PRESC_W-1:0] presc_inc = presc_wrap ? PRESC_W'(wdc_pkg::PRESC_CLR_VAL)
                                                    : presc_ff + PRESC_W'(1);
    wire logic [WDT_W-1:0]   wdt_inc   = wdt_ff + WDT_W'(1);

    wire logic nxt_hit_ff  = in_q1 ? opcode_hit : hit_ff;
    // process step in phase three, dropped after phase four
    wire logic nxt_exec_ff = in_q3 ? hit_ff : (in_q4 ? 1'b0 : exec_ff);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            hit_ff  <= 1'b0;
            exec_ff <= 1'b0;
        end else begin
            hit_ff  <= nxt_hit_ff;
            exec_ff <= nxt_exec_ff;
        end
    end

    // ****************************************************************
    // watchdog counter and prescaler
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            wdt_ff   <= WDT_W'(wdc_pkg::WDT_RST_VAL);
            presc_ff <= PRESC_W'(wdc_pkg::PRESC_RST_VAL);
            tout_ff  <= 1'b0;
        end else if (do_clear) begin
            wdt_ff   <= WDT_W'(wdc_pkg::WDT_CLEAR_VAL);
            presc_ff <= PRESC_W'(wdc_pkg::PRESC_CLR_VAL);
            tout_ff  <= 1'b0;
        end else begin
            presc_ff <= wdt_tick ? presc_inc : presc_ff;
            wdt_ff   <= presc_wrap ? wdt_inc : wdt_ff;
            tout_ff  <= wdt_wrap;
        end
    end

    // ****************************************************************
    // status flags
    // ****************************************************************
    // events clear a flag; the instruction in phase four sets it and wins over them
    always_ff @(posedge core_clk) begin
        if (rst) begin
            to_n_ff    <= wdc_pkg::FLAG_RST_VAL;
            pwrdn_n_ff <= wdc_pkg::FLAG_RST_VAL;
        end else if (do_clear) begin
            to_n_ff    <= wdc_pkg::FLAG_SET;
            pwrdn_n_ff <= wdc_pkg::FLAG_SET;
        end else begin
            to_n_ff    <= wdt_wrap ? wdc_pkg::FLAG_CLR : to_n_ff;
            pwrdn_n_ff <= sleep_entry ? wdc_pkg::FLAG_CLR : pwrdn_n_ff;
        end
    end

    // ****************************************************************
    // registered outputs
    // ****************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            done_ff      <= 1'b0;
            phase_out_ff <= 4'h0;
        end else begin
            done_ff      <= do_clear;
            phase_out_ff <= ph_if.phase;
        end
    end

    assign watchdog_counter = wdt_ff;
    assign wdt_prescaler    = presc_ff;
    assign wdt_timeout      = tout_ff;
    assign timeout_flag_n   = to_n_ff;
    assign powerdown_flag_n = pwrdn_n_ff;
    assign q_phase          = phase_out_ff;
    assign wdt_clear_done   = done_ff;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_fetch_hit;
        in_q1 && opcode_hit;
    endsequence

    sequence s_cleared;
        (wdt_ff == WDT_W'(wdc_pkg::WDT_CLEAR_VAL))
            && (presc_ff == PRESC_W'(wdc_pkg::PRESC_CLR_VAL));
    endsequence

    a_decode_hit: assert property (s_fetch_hit |-> ##1 hit_ff ##2 exec_ff)
        else $error("opcode not carried to the process step");
    a_wrong_opcode: assert property (in_q1 && !opcode_hit |-> ##4 !done_ff)
        else $error("clear done without the clear opcode");
    a_counter_zero: assert property (s_fetch_hit |-> ##4 s_cleared)
        else $error("counter not zero after clear");
    a_prescaler_zero: assert property (done_ff |-> presc_ff == PRESC_W'(wdc_pkg::PRESC_CLR_VAL))
        else $error("prescaler not cleared");
    a_flags_set: assert property (s_fetch_hit |-> ##4 (to_n_ff && pwrdn_n_ff))
        else $error("status flags not set by clear");
    a_flags_kept: assert property (!do_clear && !wdt_wrap |=> $stable(to_n_ff))
        else $error("time-out flag moved without cause");
    a_one_cycle: assert property (s_fetch_hit |-> ##4 done_ff ##1 !done_ff [*3])
        else $error("clear not finished in one instruction cycle");
    a_clear_in_q4: assert property (done_ff |-> $past(in_q4) && in_q1)
        else $error("counter clear outside phase four");
    a_q2_idle: assert property (in_q1 |=> ph_if.phase == wdc_pkg::PH_Q2 ##1 in_q3 ##1 in_q4)
        else $error("phase order broken");

    // ****************************************************************
    // assertions: event priority and quiet behaviour
    // ****************************************************************
    sequence s_exec_q4;
        in_q4 && exec_ff;
    endsequence

    sequence s_flags_high;
        to_n_ff && pwrdn_n_ff;
    endsequence

    sequence s_timeout_marked;
        tout_ff && !to_n_ff;
    endsequence

    // a word seen in phases two to four must not reach the decode latch
    a_decode_q1_only: assert property (!in_q1 |=> $stable(hit_ff))
        else $error("decode latch moved outside phase one");
    a_exec_in_q4: assert property (exec_ff |-> in_q4)
        else $error("process step outside phase four");
    a_done_spacing: assert property (done_ff |=> !done_ff [*3])
        else $error("two clears within one instruction cycle");
    a_pwrdn_kept: assert property (!do_clear && !sleep_entry |=> $stable(pwrdn_n_ff))
        else $error("power-down flag moved without cause");
    // the instruction has to win over a tick, wrap or sleep event in the same cycle
    a_clear_wins: assert property (s_exec_q4 |=> s_cleared)
        else $error("counter clear lost against a same-cycle tick");
    a_flags_win: assert property (s_exec_q4 |=> s_flags_high)
        else $error("status flags lost against a same-cycle event");
    a_tout_quiet: assert property (do_clear |=> !tout_ff)
        else $error("time-out pulse right after a clear");
    // without a clear a wrap must show up as pulse and flag
    a_timeout_mark: assert property (wdt_wrap && !do_clear |=> s_timeout_marked)
        else $error("wrap did not mark a time-out");
endmodule
`default_nettype wire

// ### sim/tb_top.sv
// testbench: watchdog-clear instruction timing, refusals and flag effects
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // small prescaler limit keeps the wrap run short
    localparam logic [7:0] PMAX = 8'h03;
    logic        core_clk;
    logic        rst;
    logic [13:0] instr_word;
    logic        instr_valid;
    logic        wdt_tick;
    logic        sleep_entry;
    logic [7:0]  watchdog_counter;
    logic [7:0]  wdt_prescaler;
    logic        wdt_timeout;
    logic        timeout_flag_n;
    logic        powerdown_flag_n;
    logic [3:0]  q_phase;
    logic        wdt_clear_done;
    logic        pulse_seen;
    logic [7:0]  snap;
    int          err_total;
    int          cmp_count;

    wdc_top #(.PRESC_MAX(PMAX)) u_wdc_top (
        .core_clk(core_clk), .rst(rst), .instr_word(instr_word), .instr_valid(instr_valid),
        .wdt_tick(wdt_tick), .sleep_entry(sleep_entry), .watchdog_counter(watchdog_counter),
        .wdt_prescaler(wdt_prescaler), .wdt_timeout(wdt_timeout),
        .timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n),
        .q_phase(q_phase), .wdt_clear_done(wdt_clear_done));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task compare(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task test_done;
        if (err_total == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // the source must line up with Q1; q_phase=8 marks a Q1 cycle
    task align;
        int i;
        for (i = 0; i < 8 && q_phase !== 4'h8; i++) @(negedge core_clk);
        if (q_phase !== 4'h8) begin
            err_total++;
            $display("mismatch q_phase expected 08 seen %h", q_phase);
            test_done();
        end
    endtask

    task issue(input logic [13:0] w, input logic v);
        instr_word  = w;
        instr_valid = v;
        @(negedge core_clk);
        instr_word  = 14'h0000;
        instr_valid = 1'b0;
    endtask

    task pulse_ticks(input int n);
        repeat (n) begin
            wdt_tick = 1'b1;
            @(negedge core_clk);
            wdt_tick = 1'b0;
            @(negedge core_clk);
        end
    endtask

    task quiet_check(input int n);
        repeat (n) begin
            compare("done_quiet", 8'h00, {7'h00, wdt_clear_done});
            @(negedge core_clk);
        end
    endtask

    // one cycle, clear lands at end of Q4
    task clear_check;
        align();
        issue(wdc_pkg::OP_WDT_CLEAR, 1'b1);
        quiet_check(3);
        compare("done", 8'h01, {7'h00, wdt_clear_done});
        compare("q_phase", 8'h08, {4'h0, q_phase});
        compare("counter", 8'h00, watchdog_counter);
        compare("prescaler", 8'h00, wdt_prescaler);
        compare("timeout_flag_n", 8'h01, {7'h00, timeout_flag_n});
        compare("powerdown_flag_n", 8'h01, {7'h00, powerdown_flag_n});
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task sc_reset;
        compare("counter", 8'h00, watchdog_counter);
        compare("flags", 8'h03, {6'h00, timeout_flag_n, powerdown_flag_n});
    endtask

    task sc_clear_after_sleep;
        pulse_ticks(9);
        compare("counter_moved", 8'h01, {7'h00, watchdog_counter != 8'h00});
        sleep_entry = 1'b1;
        @(negedge core_clk);
        sleep_entry = 1'b0;
        compare("powerdown_flag_n", 8'h00, {7'h00, powerdown_flag_n});
        clear_check();
        @(negedge core_clk);
        compare("done_end", 8'h00, {7'h00, wdt_clear_done});
    endtask

    task sc_refused;
        logic [13:0] bad [5];
        int          k;
        bad = '{14'h0065, 14'h0063, 14'h0464, 14'h2064, 14'h0000};
        pulse_ticks(9);
        snap = watchdog_counter;
        for (k = 0; k < 5; k++) begin
            align();
            issue(bad[k], 1'b1);
            quiet_check(6);
        end
        align();
        issue(wdc_pkg::OP_WDT_CLEAR, 1'b0);
        quiet_check(6);
        align();
        @(negedge core_clk);
        issue(wdc_pkg::OP_WDT_CLEAR, 1'b1);
        quiet_check(6);
        compare("counter_kept", snap, watchdog_counter);
    endtask

    task sc_timeout_then_b2b;
        int n;
        pulse_seen = 1'b0;
        for (n = 0; n < 1200 && timeout_flag_n !== 1'b0; n++) begin
            wdt_tick = 1'b1;
            @(negedge core_clk);
            wdt_tick = 1'b0;
            pulse_seen = pulse_seen | (wdt_timeout === 1'b1);
            @(negedge core_clk);
            pulse_seen = pulse_seen | (wdt_timeout === 1'b1);
        end
        compare("timeout_flag_n", 8'h00, {7'h00, timeout_flag_n});
        compare("timeout_pulse", 8'h01, {7'h00, pulse_seen});
        clear_check();
        // back-to-back: the next Q1 follows at once
        clear_check();
        @(negedge core_clk);
        compare("done_end", 8'h00, {7'h00, wdt_clear_done});
    endtask

    initial begin
        rst         = 1'b1;
        instr_word  = 14'h0000;
        instr_valid = 1'b0;
        wdt_tick    = 1'b0;
        sleep_entry = 1'b0;
        err_total   = 0;
        cmp_count   = 0;
        repeat (12) @(negedge core_clk);
        rst = 1'b0;
        sc_reset();
        sc_clear_after_sleep();
        sc_refused();
        sc_timeout_then_b2b();
        test_done();
    end

    // a hang counts as a mismatch
    initial begin
        #500000;
        err_total++;
        $display("mismatch run_time expected 0 seen 1");
        test_done();
    end
endmodule
`default_nettype wire
